// *** logic/serial_status_brg.sv ***
// serial status flags, bit-rate divisor and bit-rate generator
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - set parity error on ones-count mismatch
// - parity error cleared by read-1 then write-0
// - clearing receive enable keeps parity error
// - parity-error character stored, full flag not set
// - reception blocked while parity error set
// - transmit end read-only, resets to one
// - transmit end cleared by hold write/empty clear
// - transmit end set by disable or last bit
// - capture received multiprocessor bit, read-only
// - clearing receive enable keeps received mp bit
// - send stored multiprocessor bit each character
// - mp send bit ignored sync/disabled/idle
// - 8-bit divisor scales selected baud clock
// - divisor readable and writable at any time
// - divisor forced to ff on reset/standby
// - bit period (N+1)*64 async, *8 sync, in selected clock ticks
// - clock select: sys, sub (/2 outside sub mode), sys/16, sys/64
module serial_status_brg
  import serial_status_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic        standby_i,
  input  wire logic        sub_mode_i,
  input  wire logic        sub_clk_i,
  input  wire logic        rx_done_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_parity_i,
  input  wire logic        rx_mp_bit_i,
  input  wire logic        tx_load_i,
  input  wire logic        tx_last_bit_i,
  output logic             bit_tick_o,
  output logic      [7:0]  tx_data_o,
  output logic             tx_mp_bit_o,
  output logic             rx_stall_o,
  output logic             tx_empty_o,
  output logic      [7:0]  control_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic        par_err;
    logic        tx_end;
    logic        mp_rx;
    logic        mp_tx;
    logic        tx_empty;
    logic        rx_full;
    logic        par_arm;
    logic        empty_arm;
    logic        full_arm;
    logic [7:0]  divisor;
    logic [7:0]  control;
    logic [7:0]  tx_hold;
    logic [7:0]  rx_hold;
    logic [5:0]  pre;
    logic [5:0]  sub_cnt;
    logic [7:0]  div_cnt;
    logic        sub_half;
    logic        sub_q1;
    logic        sub_q2;
    logic        sub_q3;
    logic        bit_tick;
    logic        mp_out;
    logic        ack;
    logic [31:0] dat;
  } state_s;

  localparam state_s STATE_RST = '{
    par_err: 1'b0, tx_end: TX_END_RST, mp_rx: 1'b0, mp_tx: 1'b0,
    tx_empty: TX_EMPTY_RST, rx_full: 1'b0, par_arm: 1'b0,
    empty_arm: 1'b0, full_arm: 1'b0, divisor: DIVISOR_RST,
    control: CONTROL_RST, tx_hold: 8'h00, rx_hold: 8'h00,
    pre: 6'h00, sub_cnt: 6'h00, div_cnt: 8'h00, sub_half: 1'b0,
    sub_q1: 1'b0, sub_q2: 1'b0, sub_q3: 1'b0, bit_tick: 1'b0,
    mp_out: 1'b0, ack: 1'b0, dat: 32'h0000_0000};

  state_s s_r;
  state_s s_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // odd count of ones over a data byte plus one extra bit
  function automatic logic odd_ones(input logic [7:0] d, input logic p);
    odd_ones = (^d) ^ p;
  endfunction

  // word select of a register from the byte address
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic       src_en;
  logic       sub_edge;
  logic       rx_take;
  logic       par_bad;
  logic       async_mode;
  logic [5:0] sub_last;
  logic [7:0] status_rd;

  // ------------------------------------------------------------
  // bus decode and combinational helpers
  // ------------------------------------------------------------
  // one access per request: the ack cycle itself is not decoded again
  assign acc        = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr         = acc && wb_we_i && wb_sel_i[0];
  assign rd         = acc && !wb_we_i;
  assign async_mode = !s_r.control[CT_SYNC];
  assign sub_edge   = s_r.sub_q2 && !s_r.sub_q3;
  assign sub_last   = async_mode ? ASYNC_LAST : SYNC_LAST;
  // a parity error blocks any further character
  assign rx_take    = rx_done_i && s_r.control[CT_RX_EN] && !s_r.par_err;
  assign par_bad    = async_mode && s_r.control[CT_PAR_EN]
                      && (odd_ones(rx_data_i, rx_parity_i) != s_r.control[CT_PAR_ODD]);
  assign status_rd  = {s_r.tx_empty, s_r.rx_full, 2'b00, s_r.par_err,
                       s_r.tx_end, s_r.mp_rx, s_r.mp_tx};

  // baud source: system, subclock (halved outside sub modes), /16, /64
  always_comb begin
    case ({s_r.control[CT_CLK_HI], s_r.control[CT_CLK_LO]})
      2'b00:   src_en = 1'b1;
      2'b01:   src_en = sub_edge && (sub_mode_i || s_r.sub_half);
      2'b10:   src_en = (s_r.pre[3:0] == DIV16_LAST);
      2'b11:   src_en = (s_r.pre == DIV64_LAST);
      default: src_en = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // subclock pin: first flop feeds only the second
    s_nxt.sub_q1 = sub_clk_i;
    s_nxt.sub_q2 = s_r.sub_q1;
    s_nxt.sub_q3 = s_r.sub_q2;
    if (sub_edge) begin
      s_nxt.sub_half = !s_r.sub_half;
    end

    // free-running prescaler for the /16 and /64 taps
    s_nxt.pre = s_r.pre + 6'd1;

    // bit-rate divider: (divisor+1) steps of 64 or 8 source ticks
    s_nxt.bit_tick = 1'b0;
    if (src_en) begin
      if (s_r.sub_cnt >= sub_last) begin
        s_nxt.sub_cnt = 6'h00;
        if (s_r.div_cnt >= s_r.divisor) begin
          s_nxt.div_cnt  = 8'h00;
          s_nxt.bit_tick = 1'b1;
        end else begin
          s_nxt.div_cnt = s_r.div_cnt + 8'd1;
        end
      end else begin
        s_nxt.sub_cnt = s_r.sub_cnt + 6'd1;
      end
    end

    // bus answer: single-cycle ack, unmapped reads give zero
    s_nxt.ack = acc;
    if (rd) begin
      if (hit(wb_adr_i, STATUS_OFS)) begin
        s_nxt.dat = {24'h000000, status_rd};
      end else if (hit(wb_adr_i, DIVISOR_OFS)) begin
        s_nxt.dat = {24'h000000, s_r.divisor};
      end else if (hit(wb_adr_i, CONTROL_OFS)) begin
        s_nxt.dat = {24'h000000, s_r.control};
      end else if (hit(wb_adr_i, TX_HOLD_OFS)) begin
        s_nxt.dat = {24'h000000, s_r.tx_hold};
      end else if (hit(wb_adr_i, RX_HOLD_OFS)) begin
        s_nxt.dat = {24'h000000, s_r.rx_hold};
      end else begin
        s_nxt.dat = 32'h0000_0000;
      end
    end

    // status read arms the clear of each flag seen at one
    if (rd && hit(wb_adr_i, STATUS_OFS)) begin
      s_nxt.par_arm   = s_r.par_arm   || s_r.par_err;
      s_nxt.empty_arm = s_r.empty_arm || s_r.tx_empty;
      s_nxt.full_arm  = s_r.full_arm  || s_r.rx_full;
    end
    // reading the receive holding register empties it
    if (rd && hit(wb_adr_i, RX_HOLD_OFS)) begin
      s_nxt.rx_full = 1'b0;
    end

    // status write: only armed flags clear, a one keeps a flag; all arms drop and the mp send bit is written
    if (wr && hit(wb_adr_i, STATUS_OFS)) begin
      if (s_r.par_arm && !wb_dat_i[ST_PAR_ERR]) begin
        s_nxt.par_err = 1'b0;
      end
      if (s_r.empty_arm && !wb_dat_i[ST_TX_EMPTY]) begin
        s_nxt.tx_empty = 1'b0;
        s_nxt.tx_end   = 1'b0;
      end
      if (s_r.full_arm && !wb_dat_i[ST_RX_FULL]) begin
        s_nxt.rx_full = 1'b0;
      end
      s_nxt.mp_tx     = wb_dat_i[ST_MP_TX];
      s_nxt.par_arm   = 1'b0;
      s_nxt.empty_arm = 1'b0;
      s_nxt.full_arm  = 1'b0;
      // transmit end and received mp bit ignore writes
    end

    // divisor write restarts the divider so the new rate starts clean
    if (wr && hit(wb_adr_i, DIVISOR_OFS)) begin
      s_nxt.divisor = wb_dat_i[7:0];
      s_nxt.sub_cnt = 6'h00;
      s_nxt.div_cnt = 8'h00;
    end

    // control write; dropping transmit enable ends transmission
    if (wr && hit(wb_adr_i, CONTROL_OFS)) begin
      s_nxt.control = wb_dat_i[7:0];
      if (s_r.control[CT_TX_EN] && !wb_dat_i[CT_TX_EN]) begin
        s_nxt.tx_end = 1'b1;
      end
      // receive enable clear leaves error and mp flags alone
    end

    // a new character starts a transmission
    if (wr && hit(wb_adr_i, TX_HOLD_OFS)) begin
      s_nxt.tx_hold  = wb_dat_i[7:0];
      s_nxt.tx_empty = 1'b0;
      s_nxt.tx_end   = 1'b0;
    end

    // hardware events come last so a set beats a clear
    if (tx_load_i) begin
      s_nxt.tx_empty = 1'b1;
    end
    if (tx_last_bit_i && s_r.tx_empty) begin
      s_nxt.tx_end = 1'b1;
    end
    if (rx_take) begin
      s_nxt.rx_hold = rx_data_i;
      if (par_bad) begin
        s_nxt.par_err = 1'b1;
      end else begin
        s_nxt.rx_full = 1'b1;
      end
      if (async_mode && s_r.control[CT_MP_EN]) begin
        s_nxt.mp_rx = rx_mp_bit_i;
      end
    end

    // mp bit only counts in async mp mode while transmitting
    s_nxt.mp_out = s_nxt.mp_tx && !s_nxt.control[CT_SYNC] && s_nxt.control[CT_MP_EN]
                   && s_nxt.control[CT_TX_EN] && !s_nxt.tx_end;

    // standby forces the divisor back to its reset value
    if (standby_i) begin
      s_nxt.divisor = DIVISOR_RST;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign wb_ack_o    = s_r.ack;
  assign wb_dat_o    = s_r.dat;
  assign bit_tick_o  = s_r.bit_tick;
  assign tx_data_o   = s_r.tx_hold;
  assign tx_mp_bit_o = s_r.mp_out;
  assign rx_stall_o  = s_r.par_err;
  assign tx_empty_o  = s_r.tx_empty;
  assign control_o   = s_r.control;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [31:0] gap_r;
  logic        cfg_dirty_r;

  // cycles between bit ticks; any config write makes one gap unreliable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_r       <= 32'h0000_0000;
      cfg_dirty_r <= 1'b1;
    end else begin
      gap_r <= bit_tick_o ? 32'h0000_0001 : gap_r + 32'h0000_0001;
      if (wr || standby_i) begin
        cfg_dirty_r <= 1'b1;
      end else if (bit_tick_o) begin
        cfg_dirty_r <= 1'b0;
      end
    end
  end

  sequence status_wr0_s;
    wr && hit(wb_adr_i, STATUS_OFS) && !wb_dat_i[ST_PAR_ERR];
  endsequence
  sequence bad_char_s;
    rx_take && par_bad;
  endsequence
  parity_set_a: assert property (bad_char_s |=> s_r.par_err && !$rose(s_r.rx_full))
    else $error("parity error not flagged");
  parity_clear_a: assert property (s_r.par_err && !s_r.par_arm ##0 status_wr0_s |=> s_r.par_err)
    else $error("parity error cleared without prior read");
  parity_one_a: assert property (wr && hit(wb_adr_i, STATUS_OFS) && wb_dat_i[ST_PAR_ERR]
                                 |=> $stable(s_r.par_err) || s_r.par_err)
    else $error("writing one altered parity error");
  rx_disable_keep_a: assert property (wr && hit(wb_adr_i, CONTROL_OFS) && !wb_dat_i[CT_RX_EN]
                                      && !rx_done_i |=> $stable(s_r.par_err) && $stable(s_r.mp_rx))
    else $error("receive disable changed flags");
  bad_char_store_a: assert property (bad_char_s |=> s_r.rx_hold == $past(rx_data_i))
    else $error("bad character not stored");
  rx_stall_a: assert property (s_r.par_err && rx_done_i |=> $stable(s_r.rx_hold) && $stable(s_r.mp_rx))
    else $error("character taken while parity error set");
  tx_end_clear_a: assert property (wr && hit(wb_adr_i, TX_HOLD_OFS) && !tx_last_bit_i |=> !s_r.tx_end)
    else $error("transmit end not cleared");
  tx_end_set_a: assert property (tx_last_bit_i && s_r.tx_empty |=> s_r.tx_end[*2] or (s_r.tx_end ##1 1'b1))
    else $error("transmit end not set after last bit");
  tx_end_ro_a: assert property (wr && hit(wb_adr_i, STATUS_OFS) && !tx_last_bit_i
                                && !(s_r.empty_arm && !wb_dat_i[ST_TX_EMPTY]) |=> $stable(s_r.tx_end))
    else $error("transmit end written by software");
  mp_capture_a: assert property (rx_take && async_mode && s_r.control[CT_MP_EN]
                                 |=> s_r.mp_rx == $past(rx_mp_bit_i))
    else $error("mp bit not captured");
  mp_send_a: assert property (tx_mp_bit_o |-> s_r.mp_tx && !s_r.control[CT_SYNC] && s_r.control[CT_MP_EN])
    else $error("mp bit sent outside async mp mode");
  divisor_standby_a: assert property (standby_i |=> s_r.divisor == DIVISOR_RST)
    else $error("divisor not forced on standby");
  bit_period_a: assert property (bit_tick_o && !cfg_dirty_r && s_r.control[CT_CLK_HI:CT_CLK_LO] == 2'b00
                                 |-> gap_r == ({24'h000000, s_r.divisor} + 32'd1) * (async_mode ? 32'd64 : 32'd8))
    else $error("bit period wrong");
  div16_a: assert property (bit_tick_o && !cfg_dirty_r && s_r.control[CT_CLK_HI:CT_CLK_LO] == 2'b10
                            |-> gap_r == ({24'h000000, s_r.divisor} + 32'd1) * (async_mode ? 32'd1024 : 32'd128))
    else $error("divide-by-16 bit period wrong");
  bus_ack_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not single cycle");

endmodule
`default_nettype wire

// *** logic/serial_status_pkg.sv ***
// constants for the serial status flags and bit-rate generator
package serial_status_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS  = 8'h00;
  localparam logic [7:0] DIVISOR_OFS = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] TX_HOLD_OFS = 8'h0c;
  localparam logic [7:0] RX_HOLD_OFS = 8'h10;

  // ------------------------------------------------------------
  // status field positions
  // ------------------------------------------------------------
  localparam int ST_MP_TX   = 0;
  localparam int ST_MP_RX   = 1;
  localparam int ST_TX_END  = 2;
  localparam int ST_PAR_ERR = 3;
  localparam int ST_RX_FULL = 6;
  localparam int ST_TX_EMPTY = 7;

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CT_TX_EN   = 0;
  localparam int CT_RX_EN   = 1;
  localparam int CT_PAR_EN  = 2;
  localparam int CT_PAR_ODD = 3;
  localparam int CT_SYNC    = 4;
  localparam int CT_MP_EN   = 5;
  localparam int CT_CLK_LO  = 6;
  localparam int CT_CLK_HI  = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DIVISOR_RST  = 8'hff;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic       TX_END_RST   = 1'b1;
  localparam logic       TX_EMPTY_RST = 1'b1;

  // ------------------------------------------------------------
  // timing counts (source ticks per divisor step, prescaler taps)
  // ------------------------------------------------------------
  localparam logic [5:0] ASYNC_LAST = 6'h3f;  // 64 source ticks
  localparam logic [5:0] SYNC_LAST  = 6'h07;  // 8 source ticks
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [5:0] DIV64_LAST = 6'h3f;

endpackage

// *** tb/serial_station.sv ***
// behavioural far-side station that delivers receive characters and shifter strobes
`timescale 1ns/100ps
`default_nettype none
module serial_station (
  input  wire logic       clk_i,
  output logic            rx_done_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_parity_o,
  output logic            rx_mp_bit_o,
  output logic            tx_load_o,
  output logic            tx_last_bit_o
);
  // ----------------------------------------------------------
  // line idle state
  // ----------------------------------------------------------
  initial begin
    rx_done_o     = 1'b0;
    rx_data_o     = 8'h00;
    rx_parity_o   = 1'b0;
    rx_mp_bit_o   = 1'b0;
    tx_load_o     = 1'b0;
    tx_last_bit_o = 1'b0;
  end

  // one-cycle strobe; data is inverted afterwards so no stale value can pass for valid
  task automatic send_char(input logic [7:0] d, input logic p, input logic m);
    @(posedge clk_i);
    rx_done_o   <= 1'b1;
    rx_data_o   <= d;
    rx_parity_o <= p;
    rx_mp_bit_o <= m;
    @(posedge clk_i);
    rx_done_o   <= 1'b0;
    rx_data_o   <= ~d;
    rx_parity_o <= ~p;
    rx_mp_bit_o <= ~m;
  endtask

  // shifter took the holding register (last=0) or sent its last bit (last=1)
  task automatic pulse(input logic last);
    @(posedge clk_i);
    if (last) begin
      tx_last_bit_o <= 1'b1;
    end else begin
      tx_load_o <= 1'b1;
    end
    @(posedge clk_i);
    tx_last_bit_o <= 1'b0;
    tx_load_o     <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/serial_status_and_bit_rate_test.sv ***
// self-checking bench for the serial status flags and bit-rate generator
`timescale 1ns/100ps
`default_nettype none
module serial_status_and_bit_rate_test;
  import serial_status_pkg::*;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, standby, sub_mode, sub_clk;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_dat_o;
  logic        wb_ack_o, bit_tick_o, tx_mp_bit_o, rx_stall_o, tx_empty_o;
  logic [7:0]  tx_data_o, control_o, rx_data;
  logic        rx_done, rx_parity, rx_mp_bit, tx_load, tx_last_bit;
  logic [2:0]  sc_cnt;
  int          fails, checked;

  serial_status_brg dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .standby_i(standby), .sub_mode_i(sub_mode), .sub_clk_i(sub_clk),
    .rx_done_i(rx_done), .rx_data_i(rx_data), .rx_parity_i(rx_parity), .rx_mp_bit_i(rx_mp_bit),
    .tx_load_i(tx_load), .tx_last_bit_i(tx_last_bit), .bit_tick_o(bit_tick_o), .tx_data_o(tx_data_o),
    .tx_mp_bit_o(tx_mp_bit_o), .rx_stall_o(rx_stall_o), .tx_empty_o(tx_empty_o), .control_o(control_o));
  serial_station stn (.clk_i(clk_i), .rx_done_o(rx_done), .rx_data_o(rx_data), .rx_parity_o(rx_parity),
    .rx_mp_bit_o(rx_mp_bit), .tx_load_o(tx_load), .tx_last_bit_o(tx_last_bit));

  // ----------------------------------------------------------
  // clock and subclock
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // subclock derived from the system clock so its period is an exact 10 cycles
  always @(posedge clk_i) begin
    sc_cnt  <= (sc_cnt == 3'd4) ? 3'd0 : sc_cnt + 3'd1;
    sub_clk <= (sc_cnt == 3'd4) ? ~sub_clk : sub_clk;
  end

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic single cycle; waits for ack as long as it takes (only the watchdog ends a hang)
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= 4'h1;
    wb_dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, adr, d, q);
  endtask
  // upper bits must read zero, low byte compared under a mask
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, adr, 8'h00, q);
    chk(q & {24'hffffff, m}, {24'h000000, e});
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // skip two ticks so a restarted divider has settled, then time one full period
  task automatic period_chk(input logic [1:0] cs, input logic sync, input logic sm, input int exp);
    int n;
    int k;
    sub_mode <= sm;
    wr(CONTROL_OFS, {cs, 1'b0, sync, 4'h0});
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (bit_tick_o !== 1'b1);
    end
    chk(32'(n), 32'(exp));
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs();
    do_reset();
    rd_chk(STATUS_OFS, 8'hff, 8'h84);
    rd_chk(DIVISOR_OFS, 8'hff, 8'hff);
    wr(DIVISOR_OFS, 8'h5a);
    rd_chk(DIVISOR_OFS, 8'hff, 8'h5a);
    wr(CONTROL_OFS, 8'hc3);
    chk({24'h000000, control_o}, 32'h000000c3);
    rd_chk(8'h14, 8'hff, 8'h00);
    @(posedge clk_i);
    standby <= 1'b1;
    @(posedge clk_i);
    standby <= 1'b0;
    rd_chk(DIVISOR_OFS, 8'hff, 8'hff);
    $display("test registers done");
  endtask
  task automatic t_parity();
    do_reset();
    wr(CONTROL_OFS, 8'h06);
    stn.send_char(8'h01, 1'b0, 1'b0);
    @(negedge clk_i);
    chk({31'h0, rx_stall_o}, 32'h1);
    wr(STATUS_OFS, 8'h08);
    wr(STATUS_OFS, 8'h00);
    rd_chk(STATUS_OFS, 8'h48, 8'h08);
    stn.send_char(8'h55, 1'b0, 1'b0);
    rd_chk(RX_HOLD_OFS, 8'hff, 8'h01);
    wr(CONTROL_OFS, 8'h04);
    rd_chk(STATUS_OFS, 8'h08, 8'h08);
    wr(STATUS_OFS, 8'h00);
    rd_chk(STATUS_OFS, 8'h08, 8'h00);
    chk({31'h0, rx_stall_o}, 32'h0);
    wr(CONTROL_OFS, 8'h06);
    stn.send_char(8'h03, 1'b0, 1'b0);
    rd_chk(STATUS_OFS, 8'h48, 8'h40);
    rd_chk(RX_HOLD_OFS, 8'hff, 8'h03);
    wr(CONTROL_OFS, 8'h0e);
    stn.send_char(8'h03, 1'b0, 1'b0);
    rd_chk(STATUS_OFS, 8'h48, 8'h08);
    $display("test parity done");
  endtask
  task automatic t_mp_rx();
    do_reset();
    wr(CONTROL_OFS, 8'h22);
    stn.send_char(8'h41, 1'b0, 1'b1);
    rd_chk(STATUS_OFS, 8'h42, 8'h42);
    wr(CONTROL_OFS, 8'h20);
    rd_chk(STATUS_OFS, 8'h02, 8'h02);
    wr(CONTROL_OFS, 8'h22);
    rd_chk(RX_HOLD_OFS, 8'hff, 8'h41);
    stn.send_char(8'h42, 1'b0, 1'b0);
    wr(STATUS_OFS, 8'h02);
    rd_chk(STATUS_OFS, 8'h02, 8'h00);
    $display("test mp receive done");
  endtask
  task automatic t_tx();
    do_reset();
    wr(CONTROL_OFS, 8'h21);
    wr(STATUS_OFS, 8'h01);
    @(negedge clk_i);
    chk({31'h0, tx_mp_bit_o}, 32'h0);
    wr(TX_HOLD_OFS, 8'ha5);
    @(negedge clk_i);
    chk({24'h0, tx_data_o}, 32'ha5);
    chk({31'h0, tx_mp_bit_o}, 32'h1);
    rd_chk(STATUS_OFS, 8'h85, 8'h01);
    wr(STATUS_OFS, 8'h05);
    rd_chk(STATUS_OFS, 8'h04, 8'h00);
    wr(CONTROL_OFS, 8'h31);
    @(negedge clk_i);
    chk({31'h0, tx_mp_bit_o}, 32'h0);
    wr(CONTROL_OFS, 8'h21);
    stn.pulse(1'b1);
    rd_chk(STATUS_OFS, 8'h84, 8'h00);
    stn.pulse(1'b0);
    @(negedge clk_i);
    chk({31'h0, tx_empty_o}, 32'h1);
    stn.pulse(1'b1);
    rd_chk(STATUS_OFS, 8'h84, 8'h84);
    wr(STATUS_OFS, 8'h01);
    rd_chk(STATUS_OFS, 8'h84, 8'h00);
    wr(CONTROL_OFS, 8'h20);
    rd_chk(STATUS_OFS, 8'h04, 8'h04);
    $display("test transmit done");
  endtask
  task automatic t_rate();
    do_reset();
    wr(DIVISOR_OFS, 8'h02);
    period_chk(2'b00, 1'b0, 1'b0, 192);
    period_chk(2'b00, 1'b1, 1'b0, 24);
    period_chk(2'b01, 1'b1, 1'b1, 240);
    period_chk(2'b01, 1'b1, 1'b0, 480);
    period_chk(2'b10, 1'b1, 1'b0, 384);
    period_chk(2'b11, 1'b1, 1'b0, 1536);
    $display("test bit rate done");
  endtask

  // ----------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the whole run needs about 9000 cycles; this is over five times that
  initial begin
    #500000;
    fails++;
    wrap_up();
  end
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, standby, sub_mode, sub_clk} = 7'h41;
    wb_adr  = 8'h00;
    wb_sel  = 4'h0;
    wb_dat  = 32'h0;
    sc_cnt  = 3'd0;
    fails   = 0;
    checked = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_parity();
    t_mp_rx();
    t_tx();
    t_rate();
    wrap_up();
  end
endmodule
`default_nettype wire
